// ==== hdl/dab_pkg.sv ====
// Purpose: Shared constants and helpers of the DMA address and block unit
// Assumes: 32-bit Wishbone registers on aligned words
// Notes: Offsets are byte addresses on wb_adr
package dab_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_SRC_START = 8'h00;
    localparam logic [7:0] OFS_DST_START = 8'h04;
    localparam logic [7:0] OFS_NEXT_DESC = 8'h08;
    localparam logic [7:0] OFS_CTL_LOW = 8'h0C;
    localparam logic [7:0] OFS_CTL_HIGH = 8'h10;
    localparam logic [7:0] OFS_CONFIG = 8'h14;
    localparam logic [7:0] OFS_GATHER = 8'h18;
    localparam logic [7:0] OFS_SCATTER = 8'h1C;
    localparam logic [7:0] OFS_RAW = 8'h20;
    localparam logic [7:0] OFS_MASK = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_CLEAR = 8'h2C;
    localparam logic [7:0] OFS_COMBINED = 8'h30;
    localparam logic [7:0] OFS_CUR_SRC = 8'h34;
    localparam logic [7:0] OFS_CUR_DST = 8'h38;

    // Control low fields
    localparam int CL_SRC_DOWN = 0;
    localparam int CL_DST_DOWN = 1;
    localparam int CL_SRC_W_LO = 2;
    localparam int CL_SRC_W_HI = 3;
    localparam int CL_DST_W_LO = 4;
    localparam int CL_DST_W_HI = 5;
    localparam int CL_GATHER = 6;
    localparam int CL_SCATTER = 7;
    localparam int CTL_LO_MSB = 7;
    localparam int CTL_HI_MSB = 11;

    // Config fields
    localparam int CF_ENABLE = 0;
    localparam int CF_RELOAD_SRC = 1;
    localparam int CF_RELOAD_DST = 2;
    localparam int CF_LIST = 3;
    localparam int CF_HW_REQ = 4;
    localparam int CFG_MSB = 4;

    // Gather and scatter fields: count low, interval high
    localparam int GS_CNT_MSB = 11;
    localparam int GS_IV_LSB = 16;
    localparam int GS_IV_MSB = 31;

    // Event bits
    localparam int EV_BLOCK = 0;
    localparam int EV_XFER = 1;
    localparam int EV_DST = 2;
    localparam int EV_SRC = 3;
    localparam int EV_ERR = 4;
    localparam int EV_MSB = 4;

    // Transaction width codes
    localparam logic [1:0] W_8 = 2'h0;
    localparam logic [1:0] W_16 = 2'h1;
    localparam logic [1:0] W_32 = 2'h2;

    // Descriptor fetch
    localparam logic [2:0] DESC_LAST = 3'h4;
    localparam logic [31:0] DESC_STRIDE = 32'h0000_0004;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_FETCH = 5'h02,
        ST_WAIT = 5'h04,
        ST_XFER = 5'h08,
        ST_BLKEND = 5'h10
    } dab_state_t;

    // Bytes per transaction; reserved code behaves as 32 bits
    function automatic logic [31:0] width_bytes(input logic [1:0] w);
        case (w)
            W_8: width_bytes = 32'h0000_0001;
            W_16: width_bytes = 32'h0000_0002;
            default: width_bytes = 32'h0000_0004;
        endcase
    endfunction : width_bytes

    // Byte lane merge for Wishbone writes
    function automatic logic [31:0] wb_merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        wb_merge = r;
    endfunction : wb_merge

endpackage : dab_pkg

// ==== hdl/dab_req_sync.sv ====
// Purpose: Three-stage synchroniser for the hardware request pin
// Assumes: Pin is asynchronous to clk_sys
// Notes: Output follows only when stages two and three agree
`timescale 1ns/10ps
module dab_req_sync (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic pin,
    output logic level
);
    logic ff1;
    logic ff2;
    logic ff3;

    // First stage feeds only the second one
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ff1 <= 1'b0;
            ff2 <= 1'b0;
            ff3 <= 1'b0;
            level <= 1'b0;
        end else begin
            ff1 <= pin;
            ff2 <= ff1;
            ff3 <= ff2;
            if (ff2 == ff3) begin
                level <= ff3;
            end
        end
    end
endmodule : dab_req_sync

// ==== hdl/dab_addr_step.sv ====
// Purpose: Next pointer for one side, with gather or scatter skip
// Assumes: Count is in transactions, interval in transaction widths
// Notes: Skip goes in the same direction as the step
`timescale 1ns/10ps
module dab_addr_step (
    input wire logic [31:0] ptr,
    input wire logic down,
    input wire logic [1:0] width,
    input wire logic sg_en,
    input wire logic [11:0] sg_count,
    input wire logic [15:0] sg_interval,
    input wire logic [11:0] cnt,
    output logic [31:0] next_ptr,
    output logic [11:0] next_cnt
);
    logic [31:0] step;
    logic [31:0] skip;
    logic [11:0] cnt_inc;
    logic boundary;

    // Boundary when the sequential run reaches its count
    assign step = dab_pkg::width_bytes(width);
    assign cnt_inc = 12'(cnt + 12'h001);
    assign boundary = sg_en && (sg_count != 12'h000) && (cnt_inc == sg_count);
    assign skip = boundary ? 32'({16'h0000, sg_interval} * step) : '0;
    assign next_ptr = down ? 32'(ptr - step - skip) : 32'(ptr + step + skip);
    assign next_cnt = (boundary || !sg_en) ? 12'h000 : cnt_inc;
endmodule : dab_addr_step

// ==== hdl/dab_channel.sv ====
// Purpose: DMA channel address generation, block sequencing and events
// Assumes: Transfer engine moves one transaction per xfer_req
// Notes: LARGE_CH enables gather, scatter and descriptor chaining
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
module dab_channel #(
    parameter bit LARGE_CH = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_wr,
    output logic [31:0] wb_dat_rd,
    output logic wb_ack,
    input wire logic dma_req_pin,
    output logic xfer_req,
    output logic [31:0] xfer_src_addr,
    output logic [31:0] xfer_dst_addr,
    output logic [1:0] xfer_src_width,
    output logic [1:0] xfer_dst_width,
    input wire logic xfer_src_done,
    input wire logic xfer_dst_done,
    input wire logic xfer_err,
    output logic mem_rd_req,
    output logic [31:0] mem_rd_addr,
    input wire logic [31:0] mem_rd_data,
    input wire logic mem_rd_ack,
    input wire logic mem_rd_err,
    output logic irq
);
    typedef struct packed {
        dab_pkg::dab_state_t fsm;
        logic [31:0] src_start;
        logic [31:0] dst_start;
        logic [31:0] next_desc;
        logic [7:0] ctl_lo;
        logic [11:0] ctl_hi;
        logic [4:0] cfg;
        logic [31:0] gath;
        logic [31:0] scat;
        logic [4:0] raw;
        logic [4:0] mask;
        logic [31:0] cur_src;
        logic [31:0] cur_dst;
        logic [11:0] g_cnt;
        logic [11:0] s_cnt;
        logic [11:0] t_cnt;
        logic [2:0] f_idx;
        logic [31:0] maddr;
        logic mreq;
        logic xreq;
        logic ack;
        logic [31:0] rdat;
        logic irq;
    } dab_st_t;

    dab_st_t s;
    dab_st_t n;
    logic req_level;
    logic [31:0] nsrc;
    logic [31:0] ndst;
    logic [11:0] ng_cnt;
    logic [11:0] ns_cnt;
    logic gather_on;
    logic scatter_on;
    logic list_on;

    // Hardware request pin crossing
    dab_req_sync u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin(dma_req_pin),
        .level(req_level)
    );

    // Small channels ignore gather, scatter and list bits
    assign gather_on = LARGE_CH && s.ctl_lo[dab_pkg::CL_GATHER];
    assign scatter_on = LARGE_CH && s.ctl_lo[dab_pkg::CL_SCATTER];
    assign list_on = LARGE_CH && s.cfg[dab_pkg::CF_LIST];

    // Source side pointer step
    dab_addr_step u_src_step (
        .ptr(s.cur_src),
        .down(s.ctl_lo[dab_pkg::CL_SRC_DOWN]),
        .width(s.ctl_lo[dab_pkg::CL_SRC_W_HI:dab_pkg::CL_SRC_W_LO]),
        .sg_en(gather_on),
        .sg_count(s.gath[dab_pkg::GS_CNT_MSB:0]),
        .sg_interval(s.gath[dab_pkg::GS_IV_MSB:dab_pkg::GS_IV_LSB]),
        .cnt(s.g_cnt),
        .next_ptr(nsrc),
        .next_cnt(ng_cnt)
    );

    // Destination side pointer step
    dab_addr_step u_dst_step (
        .ptr(s.cur_dst),
        .down(s.ctl_lo[dab_pkg::CL_DST_DOWN]),
        .width(s.ctl_lo[dab_pkg::CL_DST_W_HI:dab_pkg::CL_DST_W_LO]),
        .sg_en(scatter_on),
        .sg_count(s.scat[dab_pkg::GS_CNT_MSB:0]),
        .sg_interval(s.scat[dab_pkg::GS_IV_MSB:dab_pkg::GS_IV_LSB]),
        .cnt(s.s_cnt),
        .next_ptr(ndst),
        .next_cnt(ns_cnt)
    );

    // Register read mux; unmapped offsets read zero
    function automatic logic [31:0] reg_read(input dab_st_t x,
        input logic [7:0] a);
        case (a)
            dab_pkg::OFS_SRC_START: reg_read = x.src_start;
            dab_pkg::OFS_DST_START: reg_read = x.dst_start;
            dab_pkg::OFS_NEXT_DESC: reg_read = x.next_desc;
            dab_pkg::OFS_CTL_LOW: reg_read = 32'(x.ctl_lo);
            dab_pkg::OFS_CTL_HIGH: reg_read = 32'(x.ctl_hi);
            dab_pkg::OFS_CONFIG: reg_read = 32'(x.cfg);
            dab_pkg::OFS_GATHER: reg_read = x.gath;
            dab_pkg::OFS_SCATTER: reg_read = x.scat;
            dab_pkg::OFS_RAW: reg_read = 32'(x.raw);
            dab_pkg::OFS_MASK: reg_read = 32'(x.mask);
            dab_pkg::OFS_STATUS: reg_read = 32'(x.raw & x.mask);
            dab_pkg::OFS_COMBINED: reg_read = 32'(|(x.raw & x.mask));
            dab_pkg::OFS_CUR_SRC: reg_read = x.cur_src;
            dab_pkg::OFS_CUR_DST: reg_read = x.cur_dst;
            default: reg_read = '0;
        endcase
    endfunction : reg_read

    // Whole next state: bus, sequencer, events
    always_comb begin
        logic [31:0] wv;
        logic [4:0] ev;
        logic [4:0] clr;
        logic go;
        logic [11:0] t_inc;
        wv = '0;
        ev = '0;
        clr = '0;
        go = 1'b0;
        t_inc = 12'(s.t_cnt + 12'h001);
        n = s;
        n.ack = 1'b0;

        // Ack one cycle after the strobe; write at the edge that ends the ack cycle
        if (wb_cyc && wb_stb && !s.ack) begin
            n.ack = 1'b1;
            n.rdat = reg_read(s, wb_adr);
        end
        if (wb_cyc && wb_stb && s.ack && wb_we) begin
            wv = dab_pkg::wb_merge(reg_read(s, wb_adr), wb_dat_wr, wb_sel);
            case (wb_adr)
                dab_pkg::OFS_SRC_START: n.src_start = wv;
                dab_pkg::OFS_DST_START: n.dst_start = wv;
                dab_pkg::OFS_NEXT_DESC: n.next_desc = wv;
                dab_pkg::OFS_CTL_LOW: n.ctl_lo = wv[dab_pkg::CTL_LO_MSB:0];
                dab_pkg::OFS_CTL_HIGH: n.ctl_hi = wv[dab_pkg::CTL_HI_MSB:0];
                dab_pkg::OFS_CONFIG: begin
                    n.cfg = wv[dab_pkg::CFG_MSB:0];
                    go = wv[dab_pkg::CF_ENABLE] && (s.fsm == dab_pkg::ST_IDLE);
                end
                dab_pkg::OFS_GATHER: n.gath = wv;
                dab_pkg::OFS_SCATTER: n.scat = wv;
                dab_pkg::OFS_MASK: n.mask = wv[dab_pkg::EV_MSB:0];
                dab_pkg::OFS_CLEAR, dab_pkg::OFS_STATUS: begin
                    // No merge: an unselected lane must clear nothing
                    clr = wb_sel[0] ? wb_dat_wr[dab_pkg::EV_MSB:0] : '0;
                end
                default: begin
                end
            endcase
        end

        // Block sequencer
        case (s.fsm)
            dab_pkg::ST_IDLE: begin
                if (go && LARGE_CH && wv[dab_pkg::CF_LIST]) begin
                    n.maddr = n.next_desc;
                    n.f_idx = '0;
                    n.mreq = 1'b1;
                    n.fsm = dab_pkg::ST_FETCH;
                end else if (go) begin
                    n.cur_src = s.src_start;
                    n.cur_dst = s.dst_start;
                    n.t_cnt = '0;
                    n.g_cnt = '0;
                    n.s_cnt = '0;
                    n.fsm = dab_pkg::ST_WAIT;
                end
            end
            dab_pkg::ST_FETCH: begin
                if (mem_rd_err) begin
                    ev[dab_pkg::EV_ERR] = 1'b1;
                    n.mreq = 1'b0;
                    n.cfg[dab_pkg::CF_ENABLE] = 1'b0;
                    n.fsm = dab_pkg::ST_IDLE;
                end else if (mem_rd_ack) begin
                    // Word order: source, destination, pointer, ctl lo, hi
                    case (s.f_idx)
                        3'h0: begin
                            n.src_start = mem_rd_data;
                            n.cur_src = mem_rd_data;
                        end
                        3'h1: begin
                            n.dst_start = mem_rd_data;
                            n.cur_dst = mem_rd_data;
                        end
                        3'h2: n.next_desc = mem_rd_data;
                        3'h3: begin
                            n.ctl_lo = mem_rd_data[dab_pkg::CTL_LO_MSB:0];
                        end
                        default: begin
                            n.ctl_hi = mem_rd_data[dab_pkg::CTL_HI_MSB:0];
                        end
                    endcase
                    if (s.f_idx == dab_pkg::DESC_LAST) begin
                        n.mreq = 1'b0;
                        n.t_cnt = '0;
                        n.g_cnt = '0;
                        n.s_cnt = '0;
                        n.fsm = dab_pkg::ST_WAIT;
                    end else begin
                        n.f_idx = s.f_idx + 3'h1;
                        n.maddr = s.maddr + dab_pkg::DESC_STRIDE;
                    end
                end
            end
            dab_pkg::ST_WAIT: begin
                // Software may stop the channel between transactions
                if (!s.cfg[dab_pkg::CF_ENABLE]) begin
                    n.fsm = dab_pkg::ST_IDLE;
                end else if (!s.cfg[dab_pkg::CF_HW_REQ] || req_level) begin
                    n.xreq = 1'b1;
                    n.fsm = dab_pkg::ST_XFER;
                end
            end
            dab_pkg::ST_XFER: begin
                if (xfer_err) begin
                    ev[dab_pkg::EV_ERR] = 1'b1;
                    n.xreq = 1'b0;
                    n.cfg[dab_pkg::CF_ENABLE] = 1'b0;
                    n.fsm = dab_pkg::ST_IDLE;
                end else begin
                    ev[dab_pkg::EV_SRC] = xfer_src_done;
                    if (xfer_dst_done) begin
                        ev[dab_pkg::EV_DST] = 1'b1;
                        n.xreq = 1'b0;
                        n.cur_src = nsrc;
                        n.cur_dst = ndst;
                        n.g_cnt = ng_cnt;
                        n.s_cnt = ns_cnt;
                        n.t_cnt = t_inc;
                        if (t_inc >= s.ctl_hi) begin
                            n.fsm = dab_pkg::ST_BLKEND;
                        end else begin
                            n.fsm = dab_pkg::ST_WAIT;
                        end
                    end
                end
            end
            dab_pkg::ST_BLKEND: begin
                ev[dab_pkg::EV_BLOCK] = 1'b1;
                n.t_cnt = '0;
                n.g_cnt = '0;
                n.s_cnt = '0;
                if (list_on && (s.next_desc != '0)) begin
                    n.maddr = s.next_desc;
                    n.f_idx = '0;
                    n.mreq = 1'b1;
                    n.fsm = dab_pkg::ST_FETCH;
                end else if (!list_on && (s.cfg[dab_pkg::CF_RELOAD_SRC] ||
                    s.cfg[dab_pkg::CF_RELOAD_DST])) begin
                    if (s.cfg[dab_pkg::CF_RELOAD_SRC]) begin
                        n.cur_src = s.src_start;
                    end
                    if (s.cfg[dab_pkg::CF_RELOAD_DST]) begin
                        n.cur_dst = s.dst_start;
                    end
                    n.fsm = dab_pkg::ST_WAIT;
                end else begin
                    ev[dab_pkg::EV_XFER] = 1'b1;
                    n.cfg[dab_pkg::CF_ENABLE] = 1'b0;
                    n.fsm = dab_pkg::ST_IDLE;
                end
            end
            default: begin
                n.fsm = dab_pkg::ST_IDLE;
            end
        endcase

        // Set beats clear so no event is lost
        n.raw = (s.raw & ~clr) | ev;
        n.irq = |(n.raw & n.mask);
    end

    // State register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s <= '{fsm: dab_pkg::ST_IDLE, default: '0};
        end else begin
            s <= n;
        end
    end

    // Outputs straight from state flops
    assign wb_ack = s.ack;
    assign wb_dat_rd = s.rdat;
    assign xfer_req = s.xreq;
    assign xfer_src_addr = s.cur_src;
    assign xfer_dst_addr = s.cur_dst;
    assign xfer_src_width = s.ctl_lo[dab_pkg::CL_SRC_W_HI:dab_pkg::CL_SRC_W_LO];
    assign xfer_dst_width = s.ctl_lo[dab_pkg::CL_DST_W_HI:dab_pkg::CL_DST_W_LO];
    assign mem_rd_req = s.mreq;
    assign mem_rd_addr = s.maddr;
    assign irq = s.irq;

    // Checks on the sequencer and event path
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence seq_last_dst;
        s.fsm == dab_pkg::ST_XFER && !xfer_err && xfer_dst_done &&
            (12'(s.t_cnt + 12'h001) >= s.ctl_hi);
    endsequence

    sequence seq_block_close;
        s.fsm == dab_pkg::ST_BLKEND ##1 s.raw[dab_pkg::EV_BLOCK];
    endsequence

    sequence seq_plain_step;
        s.fsm == dab_pkg::ST_XFER && !xfer_err && xfer_dst_done &&
            !gather_on && !s.ctl_lo[dab_pkg::CL_SRC_DOWN];
    endsequence

    a_start_load: assert property (
        $past(s.fsm) == dab_pkg::ST_IDLE && s.fsm == dab_pkg::ST_WAIT |->
        s.cur_src == s.src_start && s.cur_dst == s.dst_start)
        else $error("start pointers wrong");
    a_src_step_up: assert property (
        seq_plain_step |=> s.cur_src ==
        32'($past(s.cur_src) + dab_pkg::width_bytes(xfer_src_width)))
        else $error("source step wrong");
    a_gather_wrap: assert property (
        s.fsm == dab_pkg::ST_XFER && gather_on && xfer_dst_done &&
        !xfer_err && s.gath[dab_pkg::GS_CNT_MSB:0] ==
        12'(s.g_cnt + 12'h001) |=> s.g_cnt == '0)
        else $error("gather boundary missed");
    a_scatter_wrap: assert property (
        s.fsm == dab_pkg::ST_XFER && scatter_on && xfer_dst_done &&
        !xfer_err && s.scat[dab_pkg::GS_CNT_MSB:0] ==
        12'(s.s_cnt + 12'h001) |=> s.s_cnt == '0)
        else $error("scatter boundary missed");
    a_reload_src: assert property (
        s.fsm == dab_pkg::ST_BLKEND && !list_on &&
        s.cfg[dab_pkg::CF_RELOAD_SRC] |=> s.cur_src == s.src_start)
        else $error("source not reloaded");
    a_contig_dst: assert property (
        s.fsm == dab_pkg::ST_BLKEND && !list_on &&
        s.cfg[dab_pkg::CF_RELOAD_SRC] && !s.cfg[dab_pkg::CF_RELOAD_DST]
        |=> $stable(s.cur_dst)) else $error("destination moved");
    a_single_stop: assert property (
        s.fsm == dab_pkg::ST_BLKEND && !list_on &&
        !s.cfg[dab_pkg::CF_RELOAD_SRC] && !s.cfg[dab_pkg::CF_RELOAD_DST]
        |=> s.fsm == dab_pkg::ST_IDLE && s.raw[dab_pkg::EV_XFER])
        else $error("single block did not stop");
    a_fetch_addr: assert property (
        s.fsm == dab_pkg::ST_BLKEND && list_on && s.next_desc != '0
        |=> s.mreq && s.maddr == $past(s.next_desc))
        else $error("descriptor address wrong");
    a_irq_level: assert property (
        s.irq == |(s.raw & s.mask)) else $error("service request mismatch");
    a_hw_wait: assert property (
        s.fsm == dab_pkg::ST_WAIT && s.cfg[dab_pkg::CF_ENABLE] &&
        s.cfg[dab_pkg::CF_HW_REQ] && !req_level |=> !s.xreq)
        else $error("moved without request");
    a_block_len: assert property (
        seq_last_dst |=> seq_block_close) else $error("block end missed");
endmodule : dab_channel

// ==== test/dab_far_model.sv ====
// Purpose: Far side answering transactions and descriptor reads
// Assumes: One transaction or one descriptor word in flight at a time
// Notes: Read bus shows the inverse word outside acknowledged cycles
`timescale 1ns/10ps
module dab_far_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic xfer_req,
    input wire logic mem_rd_req,
    input wire logic [31:0] mem_rd_addr,
    output logic xfer_src_done,
    output logic xfer_dst_done,
    output logic mem_rd_ack,
    output logic [31:0] mem_rd_data
);
    logic [2:0] age;
    logic busy;
    // Descriptors at 0x40 and 0x54: src, dst, next, ctl low, ctl high
    logic [31:0] mem [10] = '{32'h0000_0100, 32'h0000_0200, 32'h0000_0054,
        32'h0000_0000, 32'h0000_0002, 32'h0000_0180, 32'h0000_0280,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0001};
    assign busy = xfer_req && !xfer_dst_done;
    // Slow answer: source done two cycles after the request, destination after four
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            {age, xfer_src_done, xfer_dst_done, mem_rd_ack} <= 6'h00;
        end else begin
            xfer_src_done <= busy && age == 3'h1;
            xfer_dst_done <= busy && age == 3'h3;
            age <= (busy && age != 3'h3) ? age + 3'h1 : 3'h0;
            mem_rd_ack <= mem_rd_req && !mem_rd_ack;
        end
    end
    // Stale data would hide a word taken on the wrong cycle
    assign mem_rd_data = mem_rd_ack ? mem[mem_rd_addr[5:2]] :
        ~mem[mem_rd_addr[5:2]];
endmodule : dab_far_model

// ==== test/dab_channel_bench.sv ====
// Purpose: Self-checking bench of the DMA channel address and block unit
// Assumes: Far-side model answers every transaction and descriptor read
// Notes: Error inputs tied low, so the error event is not exercised
`timescale 1ns/10ps
module dab_channel_bench;
    logic clk_sys = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic pin = 1'b0, ack, irq, xreq, sd, dd, mreq, mack;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h0000_0000, rd, q, mad, mdat, sa, da;
    logic [1:0] sw, dwd;
    int err_total = 0, n_compared = 0;
    // Rows: address, value written, value read back
    logic [71:0] rows [5] = '{{8'h00, 32'h1234_5678, 32'h1234_5678},
        {8'h10, 32'hFFFF_FFFF, 32'h0000_0FFF},
        {8'h24, 32'hFFFF_FFFF, 32'h0000_001F},
        {8'h34, 32'hFFFF_FFFF, 32'h0000_0000},
        {8'h3C, 32'hFFFF_FFFF, 32'h0000_0000}};
    always #20 clk_sys = ~clk_sys;
    dab_channel i_dut (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc(cyc),
        .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(4'hF),
        .wb_dat_wr(dw), .wb_dat_rd(rd), .wb_ack(ack), .dma_req_pin(pin),
        .xfer_req(xreq), .xfer_src_addr(sa), .xfer_dst_addr(da),
        .xfer_src_width(sw), .xfer_dst_width(dwd), .xfer_src_done(sd),
        .xfer_dst_done(dd), .xfer_err(1'b0), .mem_rd_req(mreq),
        .mem_rd_addr(mad), .mem_rd_data(mdat), .mem_rd_ack(mack),
        .mem_rd_err(1'b0), .irq(irq));
    dab_far_model i_far (.clk_sys(clk_sys), .rstn(rstn), .xfer_req(xreq),
        .mem_rd_req(mreq), .mem_rd_addr(mad), .xfer_src_done(sd),
        .xfer_dst_done(dd), .mem_rd_ack(mack), .mem_rd_data(mdat));
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Classic cycle; held until ack is sampled high
    task automatic wb(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        {cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rd;
        {cyc, stb} <= 2'b00;
        if (n >= 40) begin
            err_total++;
            stop_test();
        end
    endtask : wb
    // Poll until the channel clears its own enable bit
    task automatic wt();
        int n;
        n = 0;
        do begin
            wb(dab_pkg::OFS_CONFIG, 1'b0, 32'h0000_0000);
            n++;
        end while (q[dab_pkg::CF_ENABLE] !== 1'b0 && n < 100);
        if (n >= 100) begin
            err_total++;
            stop_test();
        end
    endtask : wt
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0000_0000);
        chk("register", e, q);
    endtask : rdc
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            wb(rows[i][71:64], 1'b1, rows[i][63:32]);
            rdc(rows[i][71:64], rows[i][31:0]);
        end
        $display("test registers done");
        // Halfword source up, word destination down, waits for request
        wb(dab_pkg::OFS_SRC_START, 1'b1, 32'h0000_0100);
        wb(dab_pkg::OFS_DST_START, 1'b1, 32'h0000_0200);
        wb(dab_pkg::OFS_CTL_LOW, 1'b1, 32'h0000_0026);
        wb(dab_pkg::OFS_CTL_HIGH, 1'b1, 32'h0000_0003);
        wb(dab_pkg::OFS_CONFIG, 1'b1, 32'h0000_0011);
        repeat (20) @(posedge clk_sys);
        chk("request", 32'h0000_0000, {31'h0, xreq});
        chk("source address", 32'h0000_0100, sa);
        chk("destination address", 32'h0000_0200, da);
        chk("widths", 32'h0000_0009, {28'h0, dwd, sw});
        pin <= 1'b1;
        wt();
        pin <= 1'b0;
        rdc(dab_pkg::OFS_CUR_SRC, 32'h0000_0106);
        rdc(dab_pkg::OFS_CUR_DST, 32'h0000_01F4);
        rdc(dab_pkg::OFS_RAW, 32'h0000_000F);
        rdc(dab_pkg::OFS_STATUS, 32'h0000_000F);
        rdc(dab_pkg::OFS_COMBINED, 32'h0000_0001);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        wb(dab_pkg::OFS_MASK, 1'b1, 32'h0000_0000);
        rdc(dab_pkg::OFS_STATUS, 32'h0000_0000);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        wb(dab_pkg::OFS_CLEAR, 1'b1, 32'h0000_001F);
        rdc(dab_pkg::OFS_RAW, 32'h0000_0000);
        $display("test single block done");
        // Gather and scatter, run twice: the pattern must repeat
        wb(dab_pkg::OFS_SRC_START, 1'b1, 32'h0000_0300);
        wb(dab_pkg::OFS_DST_START, 1'b1, 32'h0000_0400);
        wb(dab_pkg::OFS_CTL_LOW, 1'b1, 32'h0000_00C0);
        wb(dab_pkg::OFS_GATHER, 1'b1, 32'h0001_0002);
        wb(dab_pkg::OFS_SCATTER, 1'b1, 32'h0002_0001);
        repeat (2) begin
            wb(dab_pkg::OFS_CONFIG, 1'b1, 32'h0000_0001);
            wt();
            rdc(dab_pkg::OFS_CUR_SRC, 32'h0000_0304);
            rdc(dab_pkg::OFS_CUR_DST, 32'h0000_0409);
        end
        $display("test gather scatter done");
        // Source reload, destination contiguous, one-transaction blocks
        wb(dab_pkg::OFS_CLEAR, 1'b1, 32'h0000_001F);
        wb(dab_pkg::OFS_SRC_START, 1'b1, 32'h0000_0500);
        wb(dab_pkg::OFS_DST_START, 1'b1, 32'h0000_0600);
        wb(dab_pkg::OFS_CTL_LOW, 1'b1, 32'h0000_0000);
        wb(dab_pkg::OFS_CTL_HIGH, 1'b1, 32'h0000_0001);
        wb(dab_pkg::OFS_CONFIG, 1'b1, 32'h0000_0003);
        repeat (60) @(posedge clk_sys);
        // Stop only takes effect between transactions, so let it settle
        wb(dab_pkg::OFS_CONFIG, 1'b1, 32'h0000_0002);
        repeat (20) @(posedge clk_sys);
        rdc(dab_pkg::OFS_CUR_SRC, 32'h0000_0500);
        wb(dab_pkg::OFS_CUR_DST, 1'b0, 32'h0000_0000);
        chk("dst run", 32'h0000_0001, 32'(q > 32'h0000_0601));
        rdc(dab_pkg::OFS_RAW, 32'h0000_000D);
        $display("test reload done");
        // Descriptor chain of two entries; the second ends the list
        wb(dab_pkg::OFS_NEXT_DESC, 1'b1, 32'h0000_0040);
        wb(dab_pkg::OFS_CONFIG, 1'b1, 32'h0000_0009);
        wt();
        rdc(dab_pkg::OFS_CTL_HIGH, 32'h0000_0001);
        rdc(dab_pkg::OFS_CTL_LOW, 32'h0000_0000);
        rdc(dab_pkg::OFS_NEXT_DESC, 32'h0000_0000);
        rdc(dab_pkg::OFS_CUR_SRC, 32'h0000_0181);
        rdc(dab_pkg::OFS_CUR_DST, 32'h0000_0281);
        $display("test linked list done");
        // Reset in mid-run: registers return to zero, directions up
        wb(dab_pkg::OFS_CONFIG, 1'b1, 32'h0000_0003);
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        rdc(dab_pkg::OFS_CTL_LOW, 32'h0000_0000);
        $display("test reset done");
        stop_test();
    end
endmodule : dab_channel_bench
